/* File: rtl/eissm_cfg.svh */
// Offsets, field positions and reset values of the interrupt source selector
// Assumes inclusion by the selector module and the bench only
`ifndef EISSM_CFG_SVH
`define EISSM_CFG_SVH

`define EISSM_OFF_SEL_0_3      12'h008
`define EISSM_OFF_SEL_4_7      12'h00c
`define EISSM_OFF_SEL_8_11     12'h010
`define EISSM_OFF_SEL_12_15    12'h014
`define EISSM_OFF_REMAP2       12'h01c
`define EISSM_SEL_RESET        16'h0000
`define EISSM_REMAP2_RESET     1'b0
`define EISSM_RELEASE_BIT      10
`define EISSM_SEL_W            4
`define EISSM_SEL_MAX_CODE     4'h6
`define EISSM_SEL_FIELD_MSB    15

`endif

/* File: rtl/eissm_mux.sv */
// External interrupt source selector with address-valid pin release, APB slave
// Assumes pclk domain inputs; port pins arrive synchronous to pclk
//
// Function
// R1 - Lines 4 to 7 take their numbered pin from the port picked by 4-bit codes 0 to 6 in bits 15:0.
// R2 - Lines 8 to 11 take their numbered pin from the port picked by ascending 4-bit codes from port A.
// R3 - Lines 12 to 15 take their numbered pin likewise, codes above 6 being reserved.
// R4 - Every selector reads zero after reset so each line starts on port A.
// R5 - With release bit 10 clear the address-valid strobe drives its pin.
// R6 - With release bit 10 set the strobe is cut from its pin, leaving it free.
// R7 - The release bit changes only by software writes.
// R8 - Lines 0 to 3 use the same encoding in a register at offset 0x08.
// R9 - Reserved bits ignore writes and read zero, and a reserved code connects no pin.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "eissm_cfg.svh"

module eissm_mux #(
    parameter int LINES = 16,
    parameter int PORTS = 7
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [LINES-1:0]     port_a_pins,
    input  wire logic [LINES-1:0]     port_b_pins,
    input  wire logic [LINES-1:0]     port_c_pins,
    input  wire logic [LINES-1:0]     port_d_pins,
    input  wire logic [LINES-1:0]     port_e_pins,
    input  wire logic [LINES-1:0]     port_f_pins,
    input  wire logic [LINES-1:0]     port_g_pins,
    output logic      [LINES-1:0]     ext_int_lines,
    input  wire logic                 addr_valid_strobe,
    output logic                      addr_valid_pin,
    output logic                      addr_valid_pin_oe
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0]  line_port_selector_reg [LINES];
    logic        addr_valid_pin_release_reg;
    logic        setup_phase;
    logic        wr_en;
    logic [1:0]  sel_group;
    logic        sel_hit;
    logic        remap_hit;
    logic [31:0] rd_next;

    // No wait states: answer in the first access cycle
    assign setup_phase = psel && !penable;
    assign wr_en       = psel && penable && pwrite && pready;

    always_comb begin
        sel_hit   = 1'b1;
        sel_group = 2'd0;
        remap_hit = 1'b0;
        case (paddr)
            `EISSM_OFF_SEL_0_3:   sel_group = 2'd0; // see R8
            `EISSM_OFF_SEL_4_7:   sel_group = 2'd1;
            `EISSM_OFF_SEL_8_11:  sel_group = 2'd2;
            `EISSM_OFF_SEL_12_15: sel_group = 2'd3;
            `EISSM_OFF_REMAP2: begin
                sel_hit   = 1'b0;
                remap_hit = 1'b1;
            end
            default:              sel_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Selector storage and routing, one slice per line
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            localparam int GRP = gi / 4;
            localparam int LSB = (gi % 4) * 4;
            logic pin_pick;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    line_port_selector_reg[gi] <= 4'h0; // see R4
                end else if (wr_en && sel_hit && sel_group == GRP[1:0]) begin
                    // Upper half of the word is never stored, see R9
                    line_port_selector_reg[gi] <= pwdata[LSB +: 4];
                end
            end

            // Reserved codes give a quiet low line, see R9
            always_comb begin
                case (line_port_selector_reg[gi])
                    eissm_pkg::EISSM_PORT_A: pin_pick = port_a_pins[gi]; // see R1
                    eissm_pkg::EISSM_PORT_B: pin_pick = port_b_pins[gi]; // see R2
                    eissm_pkg::EISSM_PORT_C: pin_pick = port_c_pins[gi]; // see R3
                    eissm_pkg::EISSM_PORT_D: pin_pick = port_d_pins[gi];
                    eissm_pkg::EISSM_PORT_E: pin_pick = port_e_pins[gi];
                    eissm_pkg::EISSM_PORT_F: pin_pick = port_f_pins[gi];
                    eissm_pkg::EISSM_PORT_G: pin_pick = port_g_pins[gi];
                    default:                 pin_pick = 1'b0;
                endcase
            end

            // Registered to keep outputs glitch free; costs one cycle of latency
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ext_int_lines[gi] <= 1'b0;
                end else begin
                    ext_int_lines[gi] <= pin_pick; // see R1
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Address-valid pin release
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_valid_pin_release_reg <= `EISSM_REMAP2_RESET;
        end else if (wr_en && remap_hit) begin
            // Only a bus write moves it, see R7
            addr_valid_pin_release_reg <= pwdata[`EISSM_RELEASE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_valid_pin    <= 1'b0;
            addr_valid_pin_oe <= 1'b1;
        end else if (!addr_valid_pin_release_reg) begin
            addr_valid_pin    <= addr_valid_strobe; // see R5
            addr_valid_pin_oe <= 1'b1;
        end else begin
            addr_valid_pin    <= 1'b0; // see R6
            addr_valid_pin_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    always_comb begin
        rd_next = 32'h0000_0000; // see R9
        if (sel_hit) begin
            for (int k = 0; k < 4; k++) begin
                rd_next[k*4 +: 4] = line_port_selector_reg[sel_group*4 + k];
            end
        end else if (remap_hit) begin
            rd_next[`EISSM_RELEASE_BIT] = addr_valid_pin_release_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= !(sel_hit || remap_hit);
            prdata  <= pwrite ? 32'h0000_0000 : rd_next;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

endmodule

/* File: rtl/eissm_pkg.sv */
// Types of the interrupt source selector
// Assumes eissm_cfg.svh holds the offsets and reset values; the port codes 0 to 6 are defined here
package eissm_pkg;
    typedef enum logic [3:0] {
        EISSM_PORT_A = 4'h0,
        EISSM_PORT_B = 4'h1,
        EISSM_PORT_C = 4'h2,
        EISSM_PORT_D = 4'h3,
        EISSM_PORT_E = 4'h4,
        EISSM_PORT_F = 4'h5,
        EISSM_PORT_G = 4'h6
    } eissm_port_t;
endpackage

/* File: tb/eissm_mux_properties.sv */
// Timing relations of the interrupt source selector
// Assumes binding to eissm_mux, one pclk domain
`timescale 1ns/1ns
module eissm_mux_properties #(
    parameter int LINES = 16
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [LINES-1:0] port_a_pins,
    input wire logic [LINES-1:0] ext_int_lines,
    input wire logic             addr_valid_strobe,
    input wire logic             addr_valid_pin,
    input wire logic             addr_valid_pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_rel = psel && penable && pready && pwrite && paddr == 12'h01c;
    wire mapped = paddr inside {12'h008, 12'h00c, 12'h010, 12'h014, 12'h01c};
    sequence s_setup;
        psel && !penable;
    endsequence
    a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not a single cycle");
    a_slverr_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr disagrees with map");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("reserved read bits not zero");
    a_reset_port_a: assert property ($rose(presetn) |=> ext_int_lines == $past(port_a_pins))
        else $error("lines not on port a after reset");
    a_pin_follow: assert property ($past(presetn) && addr_valid_pin_oe
        |-> addr_valid_pin == $past(addr_valid_strobe))
        else $error("pin does not follow strobe");
    a_release_quiet: assert property (!addr_valid_pin_oe |-> !addr_valid_pin)
        else $error("released pin driven");
    a_release_sw: assert property ($changed(addr_valid_pin_oe) |-> $past(wr_rel) || $past(wr_rel, 2))
        else $error("release changed without write");
    a_remap_read: assert property (pready && !pwrite && paddr == 12'h01c
        |-> prdata == {21'h0, !addr_valid_pin_oe, 10'h0})
        else $error("release bit readback wrong");
endmodule

/* File: tb/eissm_mux_tb.sv */
// Self-checking bench of the interrupt source selector
// Assumes eissm_mux and the checker compiled before it
`timescale 1ns/1ns
`include "eissm_cfg.svh"
module eissm_mux_tb;
    logic        pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
    logic        addr_valid_strobe, addr_valid_pin, addr_valid_pin_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sel;
    logic [15:0] port_a_pins, port_b_pins, port_c_pins, port_d_pins, port_e_pins;
    logic [15:0] port_f_pins, port_g_pins, ext_int_lines, lf = 16'h005c;
    logic [15:0] codes [4];
    logic [111:0] pinv;
    logic [11:0] regs [5] = '{`EISSM_OFF_SEL_0_3, `EISSM_OFF_SEL_4_7, `EISSM_OFF_SEL_8_11,
                              `EISSM_OFF_SEL_12_15, `EISSM_OFF_REMAP2};
    int          n_errors, comparisons;
    assign {port_g_pins, port_f_pins, port_e_pins, port_d_pins, port_c_pins, port_b_pins,
            port_a_pins} = pinv;
    eissm_mux i_dut (.*);
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Waits at most 20 rising edges for pready; request held until it is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        logic [3:0] s;
        {presetn, psel, penable, pwrite, paddr, pwdata, pinv, addr_valid_strobe} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int j = 0; j < 5; j++) begin
            apb(1'b0, regs[j], 32'h0);
            chk("reset value", rd, 32'h0);
        end
        $display("test reset done");
        for (int k = 0; k < 40; k++) begin
            for (int j = 0; j < 4; j++) begin
                sel = k < 16 ? {16'hffff, {4{k[3:0]}}} : {rnd(), rnd()};
                codes[j] = sel[15:0];
                apb(1'b1, regs[j], sel);
                apb(1'b0, regs[j], 32'h0);
                chk("selector", rd, {16'h0, sel[15:0]});
            end
            for (int j = 0; j < 7; j++) pinv[j*16+:16] <= rnd();
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            for (int j = 0; j < 16; j++) begin
                s = codes[j/4][(j%4)*4+:4];
                chk("line", {31'h0, ext_int_lines[j]},
                    {31'h0, s < 4'h7 ? pinv[s*16+j] : 1'b0});
            end
        end
        $display("test routing done");
        apb(1'b1, 12'h018, 32'hffffffff);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        for (int k = 1; k >= 0; k--) begin
            apb(1'b1, `EISSM_OFF_REMAP2, k ? {rnd(), rnd()} | 32'h400 : 32'h0);
            apb(1'b0, `EISSM_OFF_REMAP2, 32'h0);
            chk("release bit", rd, k ? 32'h400 : 32'h0);
            for (int j = 0; j < 8; j++) begin
                @(posedge pclk) addr_valid_strobe <= rnd() > 16'h7fff;
                @(posedge pclk);
                @(negedge pclk);
                chk("pin", {addr_valid_pin_oe, addr_valid_pin},
                    k ? 32'h0 : {1'b1, addr_valid_strobe});
            end
        end
        $display("test release done");
        print_verdict();
    end
endmodule
bind eissm_mux eissm_mux_properties #(.LINES(LINES)) i_props (.*);
